// ==== port_pin_regs.vh ====
// constants for the port pin override logic
`ifndef PORT_PIN_REGS_VH
`define PORT_PIN_REGS_VH
`define PIN_COUNT 8
`define PORT_RESET_VAL 8'h00
`define PIN_OSC_OUT 3'h7
`define PIN_OSC_IN 3'h6
`define PIN_SCK 3'h5
`define PIN_MISO 3'h4
`define PIN_MOSI 3'h3
`define PIN_SS 3'h2
`define PIN_T1_COMPARE_A_OUT 3'h1
`define PIN_T1_COMPARE_B_OUT 3'h2
`define PIN_T2_COMPARE_A_OUT 3'h3
`define PIN_ICP 3'h0
`define SPI_PIN_MASK 8'h3C
`define PULLUP_NORMAL 3'h2
`endif

// ==== pin_sync.v ====
// input synchroniser: latch stand-in followed by the pin input flop
`timescale 1ns/100ps
`include "port_pin_regs.vh"
module pin_sync (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // data
    input wire [7:0] din,
    output reg [7:0] dout
);
// =====================================================
// two stages
reg [7:0] stage_r;
always @(posedge ref_clk) begin
    if (!rst_n) begin
        stage_r <= `PORT_RESET_VAL;
        dout <= `PORT_RESET_VAL;
    end else begin
        stage_r <= din;
        dout <= stage_r;
    end
end
endmodule

// ==== pin_mux.v ====
// combinational override multiplexer for one pin
`timescale 1ns/100ps
`include "port_pin_regs.vh"
module pin_mux (
    // register bits
    input wire dir_bit,
    input wire out_bit,
    input wire global_pullup_disable,
    input wire in_reset,
    input wire sleep_clamp,
    // override pairs
    input wire pullup_override_en,
    input wire pullup_override_val,
    input wire dir_override_en,
    input wire dir_override_val,
    input wire outval_override_en,
    input wire outval_override_val,
    input wire input_en_override_en,
    input wire input_en_override_val,
    // pad controls
    output wire drive_en,
    output wire drive_val,
    output wire pullup_en,
    output wire input_en
);
// =====================================================
// pull-up select
wire pu_normal = ({dir_bit, out_bit, global_pullup_disable}
    == `PULLUP_NORMAL);
assign pullup_en = !in_reset &&
    (pullup_override_en ? pullup_override_val : pu_normal);
assign drive_en = !in_reset &&
    (dir_override_en ? dir_override_val : dir_bit);
assign drive_val = outval_override_en ? outval_override_val : out_bit;
assign input_en = input_en_override_en ? input_en_override_val
    : !sleep_clamp;
endmodule

// ==== port_pin_override_mux.v ====
// second port pin control: registers, alternate functions, pad controls
`timescale 1ns/100ps
`include "port_pin_regs.vh"
module port_pin_override_mux (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // register writes
    input wire dir_wr,
    input wire out_wr,
    input wire in_wr,
    input wire [7:0] wr_data,
    // register reads
    output reg [7:0] pin_direction_bit,
    output reg [7:0] pin_output_bit,
    output reg [7:0] pin_input_bit,
    // global controls
    input wire global_pullup_disable,
    input wire sleep_deep,
    input wire [7:0] toggle_override_en,
    // clocking configuration
    input wire clk_src_int_rc,
    input wire clk_src_ext,
    input wire timer_async_select,
    input wire timer_ext_clock_select,
    // spi
    input wire spi_enable,
    input wire spi_master,
    input wire sck_out,
    input wire spi_slave_out,
    input wire spi_master_out,
    // timers
    input wire t1_compare_a_en,
    input wire t1_compare_a_out,
    input wire t1_compare_b_en,
    input wire t1_compare_b_out,
    input wire t2_compare_a_en,
    input wire t2_compare_a_out,
    input wire clock_out_en,
    input wire divided_clock_src,
    // pin change and external interrupts
    input wire [7:0] pin_change_mask,
    input wire pin_change_enable,
    input wire [7:0] ext_int_enable,
    input wire [7:0] ext_int_edge_mode,
    // pads
    input wire [7:0] pad_in,
    output reg [7:0] pad_out,
    output reg [7:0] pad_oe,
    output reg [7:0] pad_pullup,
    // alternate function inputs
    output reg [7:0] raw_alt_input,
    output reg [7:0] pin_change_source,
    output reg osc_in_pin,
    output reg timer_osc_in,
    output reg sck_in,
    output reg spi_master_in,
    output reg spi_slave_in,
    output reg spi_ss_in,
    output reg t1_capture_in,
    output reg [7:0] ext_int_wake_flag
);
// =====================================================
// helpers
function [7:0] bit_mask;
    input [2:0] idx;
    begin
        bit_mask = 8'h01 << idx;
    end
endfunction

// =====================================================
// register storage
reg [7:0] dir_r;
reg [7:0] out_r;
reg [7:0] clamp_was_r;
wire [7:0] sync_q;
wire [7:0] pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, die_oe, die_ov;
wire [7:0] drv_en, drv_val, pu_en, in_en;
wire [7:0] schmitt;
wire in_reset = !rst_n;
// timer oscillator only with internal RC
wire tosc_ok = clk_src_int_rc & timer_async_select;
wire b7_osc = (!clk_src_int_rc & !clk_src_ext) |
    (tosc_ok & !timer_ext_clock_select);
wire b6_osc = !clk_src_int_rc | tosc_ok;
wire spi_slave = spi_enable & !spi_master;
wire spi_mstr = spi_enable & spi_master;
wire [7:0] osc_mask = (b7_osc ? bit_mask(`PIN_OSC_OUT) : 8'h00) |
    (b6_osc ? bit_mask(`PIN_OSC_IN) : 8'h00);

always @(posedge ref_clk) begin
    if (!rst_n) begin
        dir_r <= `PORT_RESET_VAL;
        out_r <= `PORT_RESET_VAL;
    end else begin
        if (dir_wr) begin
            dir_r <= wr_data;
        end
        // toggle by input write or override
        if (out_wr) begin
            out_r <= wr_data ^ toggle_override_en;
        end else begin
            out_r <= out_r ^ (in_wr ? wr_data : 8'h00) ^ toggle_override_en;
        end
    end
end

// =====================================================
// override terms, combinational
// spi slave forces inputs, pull-up kept
assign pu_oe = osc_mask | (spi_slave ? `SPI_PIN_MASK : 8'h00);
assign pu_ov = (spi_slave ? (out_r & `SPI_PIN_MASK &
    {8{!global_pullup_disable}}) : 8'h00) & ~osc_mask;
assign dd_oe = pu_oe | (clock_out_en ? bit_mask(`PIN_ICP) : 8'h00);
assign dd_ov = clock_out_en ? bit_mask(`PIN_ICP) : 8'h00;
assign pv_oe = {2'b00, spi_slave, spi_slave,
    spi_mstr | t2_compare_a_en, t1_compare_b_en, t1_compare_a_en,
    clock_out_en};
assign pv_ov = {2'b00, sck_out, spi_slave_out,
    (spi_mstr & spi_master_out) | (t2_compare_a_en & t2_compare_a_out),
    t1_compare_b_out, t1_compare_a_out, divided_clock_src};
// interrupt and pin change keep input alive
assign die_oe = osc_mask | (pin_change_enable ? pin_change_mask : 8'h00)
    | ext_int_enable;
assign die_ov = ~osc_mask;

genvar g;
generate
for (g = 0; g < `PIN_COUNT; g = g + 1) begin : pins
    pin_mux u_mux (
        .dir_bit(dir_r[g]),
        .out_bit(out_r[g]),
        .global_pullup_disable(global_pullup_disable),
        .in_reset(in_reset),
        .sleep_clamp(sleep_deep),
        .pullup_override_en(pu_oe[g]),
        .pullup_override_val(pu_ov[g]),
        .dir_override_en(dd_oe[g]),
        .dir_override_val(dd_ov[g]),
        .outval_override_en(pv_oe[g]),
        .outval_override_val(pv_ov[g]),
        .input_en_override_en(die_oe[g]),
        .input_en_override_val(die_ov[g]),
        .drive_en(drv_en[g]),
        .drive_val(drv_val[g]),
        .pullup_en(pu_en[g]),
        .input_en(in_en[g])
    );
end
endgenerate

// clamp ahead of the schmitt trigger
assign schmitt = pad_in & in_en;

pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din(schmitt),
    .dout(sync_q)
);

// =====================================================
// registered outputs; one flop of latency on pad controls
always @(posedge ref_clk) begin
    if (!rst_n) begin
        pad_out <= `PORT_RESET_VAL;
        pad_oe <= `PORT_RESET_VAL;
        pad_pullup <= `PORT_RESET_VAL;
        pin_direction_bit <= `PORT_RESET_VAL;
        pin_output_bit <= `PORT_RESET_VAL;
        pin_input_bit <= `PORT_RESET_VAL;
        raw_alt_input <= `PORT_RESET_VAL;
        pin_change_source <= `PORT_RESET_VAL;
        osc_in_pin <= 1'b0;
        timer_osc_in <= 1'b0;
        sck_in <= 1'b0;
        spi_master_in <= 1'b0;
        spi_slave_in <= 1'b0;
        spi_ss_in <= 1'b0;
        t1_capture_in <= 1'b0;
        ext_int_wake_flag <= `PORT_RESET_VAL;
        clamp_was_r <= `PORT_RESET_VAL;
    end else begin
        pad_out <= drv_val & drv_en;
        pad_oe <= drv_en;
        pad_pullup <= pu_en;
        pin_direction_bit <= dir_r & ~osc_mask;
        pin_output_bit <= out_r & ~osc_mask;
        pin_input_bit <= sync_q & ~osc_mask;
        raw_alt_input <= schmitt;
        pin_change_source <= schmitt;
        osc_in_pin <= pad_in[`PIN_OSC_IN];
        timer_osc_in <= pad_in[`PIN_OSC_IN];
        sck_in <= schmitt[`PIN_SCK];
        spi_master_in <= schmitt[`PIN_MISO];
        spi_slave_in <= schmitt[`PIN_MOSI];
        spi_ss_in <= schmitt[`PIN_SS];
        t1_capture_in <= schmitt[`PIN_ICP];
        // clamp drop of a high pin seen on wake
        clamp_was_r <= ~in_en & pad_in & ext_int_edge_mode;
        ext_int_wake_flag <= clamp_was_r & in_en & ~ext_int_enable;
    end
end
endmodule

// ==== port_pin_monitor.sv ====
// concurrent checks on the port pin override mux ports
`timescale 1ns/100ps
module port_pin_monitor (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // controls
    input wire global_pullup_disable,
    input wire sleep_deep,
    input wire timer_async_select,
    input wire timer_ext_clock_select,
    input wire spi_enable,
    input wire spi_master,
    input wire t1_compare_a_en,
    input wire t1_compare_a_out,
    input wire pin_change_enable,
    input wire [7:0] ext_int_enable,
    // readback and pads
    input wire [7:0] pin_direction_bit,
    input wire [7:0] pin_output_bit,
    input wire [7:0] pad_out,
    input wire [7:0] pad_oe,
    input wire [7:0] pad_pullup,
    input wire [7:0] raw_alt_input
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // properties
    property p_rst; disable iff (1'h0) !rst_n ##1 !rst_n |->
        pad_pullup == 8'h00 && pad_oe == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("pad live in reset");
    property p_oe; pad_oe[1] == pin_direction_bit[1]; endproperty
    a_oe: assert property (p_oe) else $error("oe not dir bit");
    property p_cmp; $past(t1_compare_a_en) && pad_oe[1] |->
        pad_out[1] == $past(t1_compare_a_out); endproperty
    a_cmp: assert property (p_cmp) else $error("compare lost");
    property p_sck; $past(spi_enable && !spi_master) |-> !pad_oe[5];
    endproperty
    a_sck: assert property (p_sck) else $error("sck driven");
    property p_sckpu; $past(spi_enable && !spi_master) |-> pad_pullup[5]
        == (pin_output_bit[5] && !$past(global_pullup_disable)); endproperty
    a_sckpu: assert property (p_sckpu) else $error("sck pullup");
    property p_pu; pad_pullup[1] == (!pin_direction_bit[1] &&
        pin_output_bit[1] && !$past(global_pullup_disable)); endproperty
    a_pu: assert property (p_pu) else $error("pullup wrong");
    property p_osc; $past(timer_async_select, 2) && $past(timer_async_select)
        && !$past(timer_ext_clock_select) |-> (pin_direction_bit[7:6] |
        pin_output_bit[7:6] | pad_oe[7:6]) == 2'h0; endproperty
    a_osc: assert property (p_osc) else $error("osc pin as io");
    property p_clamp; $past(sleep_deep) && !$past(pin_change_enable) &&
        !$past(ext_int_enable[1]) |-> !raw_alt_input[1]; endproperty
    a_clamp: assert property (p_clamp) else $error("no clamp");
endmodule

// ==== pad_model.sv ====
// pad side: driven, pulled or wiggling pad levels
`timescale 1ns/100ps
module pad_model (
    input wire ref_clk,
    input wire [7:0] pad_out,
    input wire [7:0] pad_oe,
    input wire [7:0] pad_pullup,
    output wire [7:0] pad_in
);
    reg [7:0] float_r = 8'h5A;
    // floating pads flip each cycle so a stale level never passes
    always @(posedge ref_clk) float_r <= ~float_r;
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & (pad_pullup | float_r));
endmodule

// ==== port_pin_override_mux_tb.sv ====
// self-checking bench for the port pin override mux
`timescale 1ns/100ps
module port_pin_override_mux_tb;
    reg ref_clk = 0, rst_n = 0, dir_wr = 0, out_wr = 0, in_wr = 0;
    reg global_pullup_disable = 0, sleep_deep = 0, clk_src_int_rc = 1;
    reg clk_src_ext = 0, timer_async_select = 0, timer_ext_clock_select = 0;
    reg spi_enable = 0, spi_master = 0, sck_out = 0, spi_slave_out = 0;
    reg spi_master_out = 0, t1_compare_a_en = 0, t1_compare_a_out = 0;
    reg t1_compare_b_en = 0, t1_compare_b_out = 0, t2_compare_a_en = 0;
    reg t2_compare_a_out = 0, clock_out_en = 0, divided_clock_src = 0;
    reg pin_change_enable = 0;
    reg [7:0] wr_data = 0, toggle_override_en = 0, pin_change_mask = 0;
    reg [7:0] ext_int_enable = 0, ext_int_edge_mode = 0, m_dir, m_out, mask;
    reg [31:0] rnd;
    wire [7:0] pad_in, pin_direction_bit, pin_output_bit, pin_input_bit;
    wire [7:0] pad_out, pad_oe, pad_pullup, raw_alt_input, pin_change_source;
    wire [7:0] ext_int_wake_flag;
    wire osc_in_pin, timer_osc_in, sck_in, spi_master_in, spi_slave_in;
    wire spi_ss_in, t1_capture_in;
    integer err_total = 0, total_checks = 0, i;
    port_pin_override_mux i_port_pin_override_mux (.*);
    pad_model i_pad_model (.*);
    initial forever #5 ref_clk = ~ref_clk;
    // ==========
    // helpers
    task step(input integer n);
        begin
            repeat (n) @(posedge ref_clk);
            #1;
        end
    endtask
    task chk(input string what, input [7:0] seen, input [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("ERROR %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // kind 0 direction, 1 output, 2 input register
    task wr(input [1:0] kind, input [7:0] d);
        begin
            wr_data = d;
            {dir_wr, out_wr, in_wr} = {kind == 0, kind == 1, kind == 2};
            step(1);
            {dir_wr, out_wr, in_wr} = 3'h0;
            if (kind == 0) m_dir = d;
            else if (kind == 1) m_out = d;
            else m_out = m_out ^ d;
        end
    endtask
    task chk_io;
        begin
            step(6);
            mask = m_dir | (m_out & ~{8{global_pullup_disable}});
            chk("dir", pin_direction_bit, m_dir);
            chk("out", pin_output_bit, m_out);
            chk("oe", pad_oe, m_dir);
            chk("drive", pad_out & pad_oe, m_out & m_dir);
            chk("pullup", pad_pullup, ~m_dir & m_out & ~{8{global_pullup_disable}});
            chk("pin", pin_input_bit & mask, m_out & mask);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d errors %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // ==========
    // main sequence
    initial begin
        {m_dir, m_out} = 16'h0000;
        rnd = $urandom(83335);
        step(10);
        rst_n = 1;
        chk_io;
        for (i = 0; i < 40; i = i + 1) begin
            rnd = $urandom;
            global_pullup_disable = rnd[8];
            {sck_out, spi_slave_out, spi_master_out} = rnd[11:9];
            {t1_compare_a_out, t1_compare_b_out, t2_compare_a_out} = rnd[14:12];
            {pin_change_mask, ext_int_edge_mode} = {rnd[31:16]};
            wr(rnd[17:16] % 2'h3, rnd[7:0]);
            chk_io;
        end
        global_pullup_disable = 0;
        wr(0, 8'h00);
        wr(1, 8'hFF);
        chk_io;
        rst_n = 0;
        step(2);
        chk("rst pullup", pad_pullup, 8'h00);
        chk("rst oe", pad_oe, 8'h00);
        rst_n = 1;
        {m_dir, m_out} = 16'h0000;
        chk_io;
        wr(0, 8'hFF);
        wr(1, 8'hA0);
        spi_enable = 1;
        step(3);
        chk("sck oe", pad_oe & 8'h20, 8'h00);
        chk("sck pu", pad_pullup & 8'h20, 8'h20);
        spi_master = 1;
        step(3);
        chk("sck oe m", pad_oe & 8'h20, 8'h20);
        {spi_enable, spi_master} = 2'h0;
        wr(1, 8'h00);
        {t1_compare_a_en, t1_compare_b_en, t2_compare_a_en} = 3'h7;
        for (i = 0; i < 2; i = i + 1) begin
            {t1_compare_a_out, t1_compare_b_out, t2_compare_a_out} = {3{i[0]}};
            step(3);
            chk("compare", pad_out & 8'h0E, {4'h0, {3{i[0]}}, 1'h0});
        end
        {t1_compare_a_en, t1_compare_b_en, t2_compare_a_en} = 3'h0;
        toggle_override_en = 8'h01;
        step(1);
        toggle_override_en = 8'h00;
        m_out = m_out ^ 8'h01;
        chk_io;
        timer_async_select = 1;
        step(4);
        chk("osc dir", pin_direction_bit & 8'hC0, 8'h00);
        chk("osc pin", pin_input_bit & 8'hC0, 8'h00);
        chk("osc oe", pad_oe & 8'hC0, 8'h00);
        timer_async_select = 0;
        wr(0, 8'h00);
        wr(1, 8'hFF);
        sleep_deep = 1;
        step(3);
        chk("clamp", raw_alt_input, 8'h00);
        {pin_change_enable, pin_change_mask} = 9'h1FF;
        step(3);
        chk("kept", raw_alt_input, 8'hFF);
        chk("pcint", pin_change_source, 8'hFF);
        chk("alt in", {3'h0, sck_in, spi_master_in, spi_slave_in, spi_ss_in,
            t1_capture_in}, 8'h1F);
        chk("osc in", {6'h00, osc_in_pin, timer_osc_in}, 8'h03);
        // sleep with pin 1 as enabled interrupt, pin 0 configured only
        pin_change_enable = 0;
        ext_int_enable = 8'h02;
        ext_int_edge_mode = 8'h01;
        step(3);
        chk("ext keep", raw_alt_input, 8'h02);
        sleep_deep = 0;
        step(1);
        chk("wake flag", ext_int_wake_flag, 8'h01);
        step(1);
        chk("wake end", ext_int_wake_flag, 8'h00);
        finish_test;
    end
endmodule
bind port_pin_override_mux port_pin_monitor i_port_pin_monitor (.*);
